// File: adccc_pkg.sv
package adccc_pkg;
  // Control register one layout
  localparam int CC1_START_BIT = 7;
  localparam int CC1_AIN_DIS_BIT = 4;
  localparam int CC1_CHAN_LSB = 0;
  localparam logic [7:0] CC1_RESET = 8'h10;
  // Control register two layout
  localparam int CC2_IREF_BIT = 5;
  localparam int CC2_TIME_LSB = 1;
  localparam logic [7:0] CC2_RESET = 8'h10;
  // Status layout
  localparam int ST_DONE_BIT = 5;
  localparam int ST_BUSY_BIT = 4;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam int RESULT_WIDTH = 8;
  localparam int TIME_SEL_WIDTH = 3;
  localparam int COUNT_WIDTH = 11;
  // Conversion time in system clocks per time select code
  localparam logic [10:0] CONV_CYCLES_0 = 11'h027;
  localparam logic [10:0] CONV_CYCLES_2 = 11'h04E;
  localparam logic [10:0] CONV_CYCLES_3 = 11'h09C;
  localparam logic [10:0] CONV_CYCLES_4 = 11'h138;
  localparam logic [10:0] CONV_CYCLES_5 = 11'h270;
  localparam logic [10:0] CONV_CYCLES_6 = 11'h4E0;
  localparam logic [10:0] CONV_CYCLES_RSV = 11'h027;
  typedef enum logic [0:0] {
    ADCCC_IDLE = 1'b0,
    ADCCC_CONV = 1'b1
  } adccc_state_t;
endpackage : adccc_pkg

// File: adccc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module adccc_timer
  import adccc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire logic abort,
  input wire logic [TIME_SEL_WIDTH-1:0] timeSel,
  output logic done
);
  logic [COUNT_WIDTH-1:0] count;
  logic running;
  logic [COUNT_WIDTH-1:0] terminal;
  always_comb begin
    unique case (timeSel)
      3'h0: terminal = CONV_CYCLES_0;
      3'h2: terminal = CONV_CYCLES_2;
      3'h3: terminal = CONV_CYCLES_3;
      3'h4: terminal = CONV_CYCLES_4;
      3'h5: terminal = CONV_CYCLES_5;
      3'h6: terminal = CONV_CYCLES_6;
      default: terminal = CONV_CYCLES_RSV;
    endcase
  end
  // Terminal count reached
  assign done = running && !abort && (count == terminal - 11'h001);
  always_ff @(posedge clock) begin
    if (reset || abort) begin
      running <= 1'b0;
      count <= '0;
    end else if (start) begin
      running <= 1'b1;
      count <= '0;
    end else if (done) begin
      running <= 1'b0;
    end else if (running) begin
      count <= count + 11'h001;
    end
  end
endmodule : adccc_timer
`default_nettype wire

// File: adc_conversion_control.sv
// Operation
// - Start bit begins conversion on selected channel
// - At time end store result, done, interrupt
// - Start bit clears itself once begun
// - Reading result clears done flag
// - Restart clears done, keeps old result
// - Stop or slow aborts, resets controls
// - Stop or slow discards results
// - No automatic restart after low power
// - Reference disconnected in stop or slow
// - Result is unsigned eight bit code
// - Busy set at start, cleared end/stop
// - Control writes ignored in low power
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control
  import adccc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic ctrlOneWrite,
  input wire logic [7:0] ctrlOneWdata,
  input wire logic ctrlTwoWrite,
  input wire logic [7:0] ctrlTwoWdata,
  input wire logic resultRead,
  input wire logic stopOrSlow,
  input wire logic sleepMode,
  input wire logic [RESULT_WIDTH-1:0] coreResult,
  output logic [7:0] converterControlOne,
  output logic [7:0] converterControlTwo,
  output logic [RESULT_WIDTH-1:0] conversionResultReg,
  output logic [7:0] conversionStatusReg,
  output logic conversionDoneIrq,
  output logic [2:0] inputChannelSelect,
  output logic analogInputDisable,
  output logic referenceCurrentOn,
  output logic coreSample
);
  adccc_state_t state;
  logic [7:0] ctrlOne;
  logic [7:0] ctrlTwo;
  logic [RESULT_WIDTH-1:0] result;
  logic doneFlag;
  logic irq;
  logic timerDone;
  wire lowPower = stopOrSlow || sleepMode;
  // Writes ignored in low power
  wire writeOk = !lowPower;
  wire startReq = ctrlOne[CC1_START_BIT] && state == ADCCC_IDLE;
  wire finish = state == ADCCC_CONV && timerDone;
  adccc_timer timer (
    .clock(clock),
    .reset(reset),
    .start(startReq),
    .abort(stopOrSlow),
    .timeSel(ctrlTwo[CC2_TIME_LSB +: TIME_SEL_WIDTH]),
    .done(timerDone)
  );
  always_ff @(posedge clock) begin
    if (reset || stopOrSlow) begin
      ctrlOne <= CC1_RESET;
      ctrlTwo <= CC2_RESET;
    end else begin
      if (ctrlOneWrite && writeOk) begin
        ctrlOne <= ctrlOneWdata;
      end else if (startReq) begin
        ctrlOne[CC1_START_BIT] <= 1'b0;
      end
      if (ctrlTwoWrite && writeOk) begin
        ctrlTwo <= ctrlTwoWdata;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset || stopOrSlow) begin
      state <= ADCCC_IDLE;
      result <= RESULT_RESET;
      doneFlag <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq <= finish;
      unique case (state)
        ADCCC_IDLE: begin
          if (startReq) begin
            state <= ADCCC_CONV;
            doneFlag <= 1'b0;
          end else if (resultRead) begin
            doneFlag <= 1'b0;
          end
        end
        ADCCC_CONV: begin
          if (finish) begin
            state <= ADCCC_IDLE;
            result <= coreResult;
            doneFlag <= 1'b1;
          end
        end
      endcase
    end
  end
  assign converterControlOne = ctrlOne;
  assign converterControlTwo = ctrlTwo;
  assign conversionResultReg = result;
  assign conversionStatusReg = {2'b00, doneFlag, state == ADCCC_CONV,
    4'h0};
  assign conversionDoneIrq = irq;
  assign inputChannelSelect = ctrlOne[CC1_CHAN_LSB +: 3];
  assign analogInputDisable = ctrlOne[CC1_AIN_DIS_BIT];
  assign referenceCurrentOn = ctrlTwo[CC2_IREF_BIT] && !stopOrSlow;
  assign coreSample = state == ADCCC_CONV;

  start_clears_a: assert property (@(posedge clock) disable iff (reset)
    startReq && !stopOrSlow |=> !ctrlOne[CC1_START_BIT] || $past(ctrlOneWrite))
    else $error("start bit not cleared");
  busy_start_a: assert property (@(posedge clock) disable iff (reset)
    startReq && !stopOrSlow |=> conversionStatusReg[ST_BUSY_BIT])
    else $error("busy not set");
  done_store_a: assert property (@(posedge clock) disable iff (reset)
    finish && !stopOrSlow |=> doneFlag && result == $past(coreResult)
    && conversionDoneIrq) else $error("completion wrong");
  read_clear_a: assert property (@(posedge clock) disable iff (reset)
    resultRead && state == ADCCC_IDLE && !startReq |=> !doneFlag)
    else $error("done not cleared on read");
  restart_keep_a: assert property (@(posedge clock) disable iff (reset)
    startReq && !stopOrSlow |=> !doneFlag && result == $past(result))
    else $error("restart handling wrong");
  stop_abort_a: assert property (@(posedge clock) disable iff (reset)
    stopOrSlow |=> state == ADCCC_IDLE && ctrlOne == CC1_RESET
    && ctrlTwo == CC2_RESET) else $error("stop did not abort");
  stop_clear_a: assert property (@(posedge clock) disable iff (reset)
    stopOrSlow |=> result == RESULT_RESET && !doneFlag)
    else $error("result not discarded");
  ref_off_a: assert property (@(posedge clock) disable iff (reset)
    stopOrSlow |-> !referenceCurrentOn)
    else $error("reference on in stop");
  no_write_a: assert property (@(posedge clock) disable iff (reset)
    sleepMode && !stopOrSlow && ctrlTwoWrite |=> ctrlTwo == $past(ctrlTwo))
    else $error("write in low power");
  idle_stay_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_IDLE && !startReq |=> state == ADCCC_IDLE)
    else $error("spontaneous start");
  fast_conv_a: assert property (@(posedge clock) disable iff (reset)
    startReq && ctrlTwo[3:1] == 3'h0 && !stopOrSlow
    |=> !finish [*8]) else $error("conversion too short");
  // Completion and stop side effects
  irq_pulse_a: assert property (@(posedge clock) disable iff (reset)
    conversionDoneIrq |=> !conversionDoneIrq)
    else $error("interrupt longer than one cycle");
  irq_cause_a: assert property (@(posedge clock) disable iff (reset)
    conversionDoneIrq |-> $past(finish))
    else $error("interrupt without completion");
  irq_done_a: assert property (@(posedge clock) disable iff (reset)
    conversionDoneIrq |-> doneFlag)
    else $error("interrupt without done flag");
  busy_clear_a: assert property (@(posedge clock) disable iff (reset)
    finish && !stopOrSlow |=> !conversionStatusReg[ST_BUSY_BIT])
    else $error("busy not cleared at end");
  stop_busy_a: assert property (@(posedge clock) disable iff (reset)
    stopOrSlow |=> !conversionStatusReg[ST_BUSY_BIT])
    else $error("busy not cleared by stop");
  // Conversion progress
  start_begin_a: assert property (@(posedge clock) disable iff (reset)
    startReq && !stopOrSlow |=> coreSample && state == ADCCC_CONV)
    else $error("conversion did not begin");
  conv_hold_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_CONV && !finish && !stopOrSlow |=> state == ADCCC_CONV)
    else $error("conversion ended early");
  result_hold_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_CONV && !finish && !stopOrSlow
    |=> result == $past(result))
    else $error("old result lost");
  done_hold_a: assert property (@(posedge clock) disable iff (reset)
    doneFlag && !resultRead && !startReq && !stopOrSlow |=> doneFlag)
    else $error("done flag dropped");
  chan_stable_a: assert property (@(posedge clock) disable iff (reset)
    state == ADCCC_CONV && !stopOrSlow && !ctrlOneWrite
    |=> inputChannelSelect == $past(inputChannelSelect))
    else $error("channel moved while converting");
  // Start bit may still self-clear while writes are blocked
  sleep_one_a: assert property (@(posedge clock) disable iff (reset)
    lowPower && !stopOrSlow && ctrlOneWrite
    |=> ctrlOne[6:0] == $past(ctrlOne[6:0]))
    else $error("control one written in low power");
  cover property (@(posedge clock) disable iff (reset) finish);
  cover property (@(posedge clock) disable iff (reset)
    state == ADCCC_CONV && stopOrSlow);
  cover property (@(posedge clock) disable iff (reset)
    doneFlag && resultRead);
  cover property (@(posedge clock) disable iff (reset)
    startReq && doneFlag);
  cover property (@(posedge clock) disable iff (reset)
    sleepMode && ctrlOneWrite);
endmodule : adc_conversion_control
`default_nettype wire

// File: adccc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adccc_core_model
  import adccc_pkg::*;
(
  input wire logic clock,
  input wire logic coreSample,
  input wire logic [2:0] inputChannelSelect,
  output var logic [RESULT_WIDTH-1:0] coreResult = 8'h5a
);
  // Idle core shows a toggling code, never a held value
  always_ff @(posedge clock) begin
    if (coreSample)
      coreResult <= {inputChannelSelect, ~inputChannelSelect, 2'h1};
    else
      coreResult <= ~coreResult;
  end
endmodule : adccc_core_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import adccc_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic ctrlOneWrite = 1'b0, ctrlTwoWrite = 1'b0, resultRead = 1'b0;
  logic stopOrSlow = 1'b0, sleepMode = 1'b0;
  logic [7:0] ctrlOneWdata = 8'h00, ctrlTwoWdata = 8'h00, lastRes = 8'h00;
  logic [7:0] ctl1, ctl2, res, stat, coreResult;
  logic irq, aDis, refOn, samp;
  logic [2:0] chan;
  int numErrors = 0, nChecks = 0;
  int cyc [8] = '{39, 39, 78, 156, 312, 624, 1248, 39};

  adc_conversion_control i_dut (.clock(clock), .reset(reset),
    .ctrlOneWrite(ctrlOneWrite), .ctrlOneWdata(ctrlOneWdata),
    .ctrlTwoWrite(ctrlTwoWrite), .ctrlTwoWdata(ctrlTwoWdata),
    .resultRead(resultRead), .stopOrSlow(stopOrSlow),
    .sleepMode(sleepMode), .coreResult(coreResult),
    .converterControlOne(ctl1), .converterControlTwo(ctl2),
    .conversionResultReg(res), .conversionStatusReg(stat),
    .conversionDoneIrq(irq), .inputChannelSelect(chan),
    .analogInputDisable(aDis), .referenceCurrentOn(refOn),
    .coreSample(samp));
  adccc_core_model i_core (.clock(clock), .coreSample(samp),
    .inputChannelSelect(chan), .coreResult(coreResult));

  initial forever #2.5 clock = ~clock;

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    nChecks++;
    if (g !== e) begin
      numErrors++;
      $display("mismatch at %0t: %h vs %h", $time, g, e);
    end
  endtask : chk

  task automatic chkCount(input int g, input int e);
    nChecks++;
    if (g != e) begin
      numErrors++;
      $display("mismatch at %0t: %h vs %h", $time, g, e);
    end
  endtask : chkCount

  task automatic wr(input logic two, input logic [7:0] d);
    @(posedge clock);
    ctrlOneWrite <= !two;
    ctrlTwoWrite <= two;
    ctrlOneWdata <= d;
    ctrlTwoWdata <= d;
    @(posedge clock);
    ctrlOneWrite <= 1'b0;
    ctrlTwoWrite <= 1'b0;
  endtask : wr

  // Channel and time select share one code; start follows setup
  task automatic conv(input logic [2:0] ch, input int n);
    int k;
    logic hit;
    wr(1'b1, 8'h30 | {4'h0, ch, 1'b0});
    wr(1'b0, 8'ha0 | {5'h00, ch});
    @(posedge clock);
    #1;
    k = 2;
    chk(ctl1 & 8'h80, 8'h00);
    chk(stat, 8'h10);
    chk(res, lastRes);
    chk({samp, chan, 4'h0}, {1'b1, ch, 4'h0});
    chk({7'h00, aDis}, 8'h00);
    // Other inputs stay quiet while converting
    while (stat[ST_DONE_BIT] !== 1'b1 && k < 1300) begin
      @(posedge clock);
      #1;
      k++;
    end
    chkCount(k, n + 2);
    lastRes = {ch, ~ch, 2'h1};
    chk(res, lastRes);
    chk(stat, 8'h20);
    hit = irq;
    @(posedge clock);
    #1;
    chk({6'h00, hit, irq}, 8'h02);
  endtask : conv

  task automatic readResult;
    chk(stat, 8'h20);
    @(posedge clock);
    resultRead <= 1'b1;
    @(posedge clock);
    resultRead <= 1'b0;
    @(posedge clock);
    #1;
    chk(stat, 8'h00);
  endtask : readResult

  task automatic lowPower;
    wr(1'b1, 8'h3c);
    wr(1'b0, 8'ha5);
    repeat (10) @(posedge clock);
    stopOrSlow <= 1'b1;
    #1;
    chk({7'h00, refOn}, 8'h00);
    @(posedge clock);
    #1;
    chk(ctl1, 8'h10);
    chk(ctl2, 8'h10);
    chk({7'h00, aDis}, 8'h01);
    chk(stat, 8'h00);
    chk(res, 8'h00);
    wr(1'b0, 8'ha1);
    @(posedge clock);
    #1;
    chk(ctl1, 8'h10);
    @(posedge clock);
    stopOrSlow <= 1'b0;
    sleepMode <= 1'b1;
    wr(1'b1, 8'h3c);
    @(posedge clock);
    #1;
    chk(ctl2, 8'h10);
    @(posedge clock);
    sleepMode <= 1'b0;
    repeat (1300) @(posedge clock);
    #1;
    chk({stat[7:1], samp}, 8'h00);
  endtask : lowPower

  task automatic stop_test;
    $display("errors %0d checks %0d", numErrors, nChecks);
    if (numErrors == 0 && nChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    numErrors++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk(ctl1, 8'h10);
    chk(ctl2, 8'h10);
    chk(stat, 8'h00);
    for (int i = 0; i < 8; i++) begin
      conv(3'(i), cyc[i]);
      if (i % 2 == 1) readResult();
    end
    lowPower();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
